/* File: hdl/sft_top.sv */
// SPI frame sequencer: transmit buffer, slave link end and top level
// Notes on behaviour
// - Idle serial clock rests at polarity level
// - Phase selects first or second edge capture
// - Idle: frame select high, transmit line low
// - Master drives clock pad, slave leaves it
// - Frame starts when enabled with buffered data
// - Phase zero slave shows bit at select fall
// - Mode 0: bit after half, rise after another
// - Mode 2: bit after half, fall after another
// - Mode 1: data and first rising edge together
// - Mode 3: data and first falling edge together
// - Select released one period after last capture
// - Phase zero: select pulses high between words
// - Phase zero slave word frozen while selected
// - Phase one: select stays low between words
// - Continuous end releases select one period later
// - Frames carry 4 to 16 bits, MSB first

// Word buffer between the stream input and the sequencer
module sft_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Storage and pointers with one wrap bit
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } sft_fifo_st_t;
    sft_fifo_st_t r;
    sft_fifo_st_t next_r;
    logic full; // Every slot taken
    logic empty; // No slot taken
    // Equal pointers mean empty, differing wrap bit only means full
    assign empty = (r.wptr == r.rptr);
    assign full = (r.wptr[AW-1:0] == r.rptr[AW-1:0]) && (r.wptr[AW] != r.rptr[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = r.mem[r.rptr[AW-1:0]];
    // Push and pop
    always_comb begin
        next_r = r;
        // Store when room
        if (in_valid && !full) begin
            next_r.mem[r.wptr[AW-1:0]] = in_data;
            next_r.wptr = r.wptr + (AW+1)'(1);
        end
        // Drop head when taken
        if (out_ready && !empty) begin
            next_r.rptr = r.rptr + (AW+1)'(1);
        end
        // Synchronous clear
        if (rst) begin
            next_r = '0;
        end
    end
    // State register
    always_ff @(posedge clk) begin
        r <= next_r;
    end
endmodule : sft_fifo

// Slave end on the external serial clock, capture edge made rising
module sft_link_slave (
    // Capture clock and select
    input wire logic link_clk,
    input wire logic frame_select_n,
    input wire logic rst,
    // Frame length minus one
    input wire logic [3:0] bits_m1,
    // Received serial bit
    input wire logic rx_bit,
    // Bits captured, finished word and its toggle
    output logic [3:0] idx,
    output logic [sft_pkg::WORD_W-1:0] hold,
    output logic done_tgl
);
    import sft_pkg::*;
    logic [WORD_W-1:0] sh; // Receive shifter
    // Shifter held clear while not selected, so it cannot drift
    always_ff @(posedge link_clk or posedge frame_select_n) begin
        if (frame_select_n) begin
            idx <= BIT_IDX_RST;
            sh <= WORD_RST;
        end else begin
            sh <= {sh[WORD_W-2:0], rx_bit};
            // Wrap for back to back words in one frame
            idx <= (idx == bits_m1) ? BIT_IDX_RST : idx + 4'h1;
        end
    end
    // Word hand-over, toggle crosses to the system domain
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            hold <= WORD_RST;
            done_tgl <= 1'b0;
        end else if (!frame_select_n && idx == bits_m1) begin
            hold <= {sh[WORD_W-2:0], rx_bit};
            done_tgl <= ~done_tgl;
        end
    end
endmodule : sft_link_slave

// Top level: master sequencer, slave data path and pads
module sft_top (
    // System clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // Configuration, steady while the port runs
    input wire logic PORT_ENABLE,
    input wire logic SLAVE_MODE,
    input wire logic CLOCK_IDLE_POLARITY,
    input wire logic CLOCK_CAPTURE_PHASE,
    input wire logic [3:0] FRAME_BITS_M1,
    // Transmit word stream
    input wire logic [sft_pkg::WORD_W-1:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    // Receive word stream
    output logic [sft_pkg::WORD_W-1:0] RX_DATA,
    output logic RX_VALID,
    // Status
    output logic BUSY,
    // Serial clock pad
    input wire logic SERIAL_CLOCK_I,
    output logic SERIAL_CLOCK_O,
    output logic SERIAL_CLOCK_OE,
    // Frame select pad
    input wire logic FRAME_SELECT_N_I,
    output logic FRAME_SELECT_N_O,
    output logic FRAME_SELECT_N_OE,
    // Data lines
    output logic SERIAL_TX_LINE_O,
    output logic SERIAL_TX_LINE_OE,
    input wire logic SERIAL_RX_LINE_I
);
    import sft_pkg::*;

    // Whole sequencer state
    typedef struct packed {
        sft_state_t st;
        logic [HCNT_W-1:0] hcnt; // Cycles in half period
        logic [ECNT_W-1:0] ecnt; // Clock edges made
        logic [1:0] tail; // Halves left before release
        logic [WORD_W-1:0] tx_sh; // MSB-aligned transmit shifter
        logic [WORD_W-1:0] rx_sh; // Receive shifter
        logic sclk;
        logic sel_n;
        logic tx;
        logic tx_oe;
        logic [WORD_W-1:0] rx_data;
        logic rx_valid;
        logic [WORD_W-1:0] slv_word; // Word the slave sends
        logic slv_loaded; // Slave word taken this gap
        logic [1:0] rx_sync;
        logic [1:0] sel_sync;
        logic [2:0] done_sync;
    } sft_top_st_t;
    sft_top_st_t r;
    sft_top_st_t next_r;

    logic fifo_valid; // Buffer head present
    logic [WORD_W-1:0] fifo_data; // Buffer head
    logic m_pop; // Master takes a word
    logic s_pop; // Slave takes a word
    logic m_cap; // Capture edge this cycle
    logic m_last_cap; // Final capture, frame ends
    logic m_cont; // Final capture, next word follows
    logic link_clk; // Slave capture clock
    logic [3:0] link_idx; // Slave bits captured
    logic [WORD_W-1:0] link_hold; // Slave finished word
    logic link_tgl; // Slave word event
    logic [3:0] bm1; // Clamped length minus one
    logic slave_bit; // Slave outgoing bit

    // Length below four is raised to four
    function automatic logic [3:0] sft_bits_m1(input logic [3:0] v);
        return (v < BITS_M1_MIN) ? BITS_M1_MIN : v;
    endfunction : sft_bits_m1

    // Keep only the low length bits of a word
    function automatic logic [WORD_W-1:0] sft_mask(input logic [WORD_W-1:0] w,
                                                   input logic [3:0] m);
        return w & ~(16'hfffe << m);
    endfunction : sft_mask

    // Move the frame's MSB to the top of the shifter
    function automatic logic [WORD_W-1:0] sft_align(input logic [WORD_W-1:0] w,
                                                    input logic [3:0] m);
        return w << (4'hf - m);
    endfunction : sft_align

    assign bm1 = sft_bits_m1(FRAME_BITS_M1);

    // Transmit buffer, drained by whichever role is active
    sft_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .in_data(TX_DATA),
        .in_valid(TX_VALID),
        .in_ready(TX_READY),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(m_pop || s_pop)
    );

    // Capture edge turned rising for every mode
    assign link_clk = SERIAL_CLOCK_I ^ (CLOCK_IDLE_POLARITY ^ CLOCK_CAPTURE_PHASE);

    // Slave end on the link clock
    sft_link_slave u_slave (
        .link_clk(link_clk),
        .frame_select_n(FRAME_SELECT_N_I),
        .rst(SYS_RST),
        .bits_m1(bm1),
        .rx_bit(SERIAL_RX_LINE_I),
        .idx(link_idx),
        .hold(link_hold),
        .done_tgl(link_tgl)
    );

    // Slave bit at once from select fall, advances after capture
    assign slave_bit = r.slv_word[bm1 - link_idx];

    // Next state of the sequencer
    always_comb begin
        logic tick;
        logic cap;
        logic more;
        logic [ECNT_W-1:0] k;
        logic [ECNT_W-1:0] nedge;
        logic [ECNT_W-1:0] end_cap;
        next_r = r;
        tick = (r.hcnt == HALF_LAST);
        k = r.ecnt + ECNT_W'(1);
        // Two edges per bit
        nedge = {1'b0, bm1, 1'b0} + 6'h02;
        end_cap = CLOCK_CAPTURE_PHASE ? nedge : nedge - 6'h01;
        // Odd edges capture at phase zero, even at phase one
        cap = k[0] ^ CLOCK_CAPTURE_PHASE;
        more = PORT_ENABLE && !SLAVE_MODE && fifo_valid;
        m_pop = 1'b0;
        s_pop = 1'b0;
        m_cap = 1'b0;
        m_last_cap = 1'b0;
        m_cont = 1'b0;
        next_r.rx_valid = 1'b0;
        // Synchronisers
        next_r.rx_sync = {r.rx_sync[0], SERIAL_RX_LINE_I};
        next_r.sel_sync = {r.sel_sync[0], FRAME_SELECT_N_I};
        next_r.done_sync = {r.done_sync[1:0], link_tgl};
        // Half period timer
        next_r.hcnt = tick ? HCNT_RST : r.hcnt + HCNT_W'(1);
        case (r.st)
            ST_IDLE: begin
                // Lines at rest
                next_r.hcnt = HCNT_RST;
                next_r.ecnt = ECNT_RST;
                next_r.sclk = CLOCK_IDLE_POLARITY;
                next_r.sel_n = SEL_IDLE;
                next_r.tx = TX_IDLE;
                next_r.tx_oe = 1'b0;
                // Start: select low, transmit output on
                if (more) begin
                    m_pop = 1'b1;
                    next_r.sel_n = 1'b0;
                    next_r.tx_oe = 1'b1;
                    next_r.tx_sh = sft_align(fifo_data, bm1);
                    next_r.st = CLOCK_CAPTURE_PHASE ? ST_SHIFT : ST_LEAD;
                end
            end
            ST_LEAD: begin
                // Phase zero: MSB out a half period after select falls
                if (tick) begin
                    next_r.tx = r.tx_sh[WORD_W-1];
                    next_r.st = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (tick) begin
                    // One clock edge every half period
                    next_r.ecnt = k;
                    next_r.sclk = ~r.sclk;
                    if (cap) begin
                        // Capture and ready the next bit
                        m_cap = 1'b1;
                        next_r.rx_sh = {r.rx_sh[WORD_W-2:0], r.rx_sync[1]};
                        next_r.tx_sh = {r.tx_sh[WORD_W-2:0], 1'b0};
                        if (k == end_cap) begin
                            next_r.rx_data = sft_mask({r.rx_sh[WORD_W-2:0], r.rx_sync[1]}, bm1);
                            next_r.rx_valid = 1'b1;
                        end
                    end else begin
                        // Launch edge drives the next bit
                        next_r.tx = r.tx_sh[WORD_W-1];
                    end
                    if (k == nedge) begin
                        if (CLOCK_CAPTURE_PHASE && more) begin
                            // Next word follows, select kept low
                            m_pop = 1'b1;
                            m_cont = 1'b1;
                            next_r.tx_sh = sft_align(fifo_data, bm1);
                            next_r.ecnt = ECNT_RST;
                        end else begin
                            // One period from last capture to release
                            next_r.st = ST_TAIL;
                            next_r.tail = CLOCK_CAPTURE_PHASE ? TAIL_PH1 : TAIL_PH0;
                        end
                    end
                    if (cap && k == end_cap && !(CLOCK_CAPTURE_PHASE && more)) begin
                        m_last_cap = 1'b1;
                    end
                end
            end
            ST_TAIL: begin
                if (tick) begin
                    if (r.tail == TAIL_PH0) begin
                        // Release select, line back to rest
                        next_r.sel_n = SEL_IDLE;
                        next_r.tx = TX_IDLE;
                        next_r.tx_oe = 1'b0;
                        next_r.st = ST_GAP;
                    end else begin
                        next_r.tail = r.tail - 2'h1;
                    end
                end
            end
            ST_GAP: begin
                // Select stays high a half period before any new word
                if (tick) begin
                    next_r.st = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
        // Slave loads one word per deselected gap, frozen while selected
        if (SLAVE_MODE && PORT_ENABLE && r.sel_sync[1] && !r.slv_loaded && fifo_valid) begin
            s_pop = 1'b1;
            next_r.slv_word = fifo_data;
            next_r.slv_loaded = 1'b1;
        end
        if (!r.sel_sync[1]) begin
            next_r.slv_loaded = 1'b0;
        end
        // Slave word finished on the link side
        if (r.done_sync[2] ^ r.done_sync[1]) begin
            next_r.rx_data = sft_mask(link_hold, bm1);
            next_r.rx_valid = 1'b1;
        end
        // Synchronous reset, select at rest
        if (SYS_RST) begin
            next_r = '0;
            next_r.sel_n = SEL_IDLE;
            // Synced select starts at its idle level, so no slave frame is seen
            next_r.sel_sync = {SEL_IDLE, SEL_IDLE};
        end
    end

    // State register
    always_ff @(posedge CLK_SYS) begin
        r <= next_r;
    end

    // Pads: master owns clock and select, slave receives them
    assign SERIAL_CLOCK_O = r.sclk;
    assign SERIAL_CLOCK_OE = !SLAVE_MODE;
    assign FRAME_SELECT_N_O = r.sel_n;
    assign FRAME_SELECT_N_OE = !SLAVE_MODE;
    // Slave line low and off while not selected
    assign SERIAL_TX_LINE_O = SLAVE_MODE ? (slave_bit && !r.sel_sync[1]) : r.tx;
    assign SERIAL_TX_LINE_OE = SLAVE_MODE ? (PORT_ENABLE && !r.sel_sync[1]) : r.tx_oe;
    assign RX_DATA = r.rx_data;
    assign RX_VALID = r.rx_valid;
    assign BUSY = (r.st != ST_IDLE) || (SLAVE_MODE && !r.sel_sync[1]);

    // Checks on the system clock
    default clocking sft_cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);
    localparam int LEAD_A = HALF_CYC;
    localparam int EDGE0_A = 2 * HALF_CYC - 7;
    localparam int TAIL_A = 2 * HALF_CYC + 1;

    // Phase zero lead: clock quiet, then first edge
    sequence quiet_lead;
        ($stable(SERIAL_CLOCK_O)) [*8];
    endsequence
    sequence release_after_tail;
        ##TAIL_A $rose(FRAME_SELECT_N_O);
    endsequence

    idle_clock_a: assert property ((r.st == ST_IDLE) |=>
        (SERIAL_CLOCK_O == $past(CLOCK_IDLE_POLARITY)))
        else $error("idle clock not at polarity level");
    capture_edge_a: assert property (m_cap |=>
        (SERIAL_CLOCK_O == (CLOCK_IDLE_POLARITY ^ CLOCK_CAPTURE_PHASE ^ 1'b1)))
        else $error("capture on wrong clock edge");
    idle_lines_a: assert property ((r.st == ST_IDLE && !SLAVE_MODE) |->
        (FRAME_SELECT_N_O && !SERIAL_TX_LINE_O && !SERIAL_TX_LINE_OE))
        else $error("idle select or transmit line wrong");
    clock_pad_a: assert property ((!SLAVE_MODE && $changed(SERIAL_CLOCK_O)) |->
        SERIAL_CLOCK_OE)
        else $error("master clock toggles with pad off");
    frame_start_a: assert property ($fell(FRAME_SELECT_N_O) |->
        ($past(fifo_valid) && $past(PORT_ENABLE) && SERIAL_TX_LINE_OE))
        else $error("frame started without data or enable");
    lead_phase0_a: assert property (($fell(FRAME_SELECT_N_O) && !CLOCK_CAPTURE_PHASE) |->
        quiet_lead ##EDGE0_A $changed(SERIAL_CLOCK_O))
        else $error("phase zero first edge misplaced");
    lead_phase1_a: assert property (($fell(FRAME_SELECT_N_O) && CLOCK_CAPTURE_PHASE) |->
        ##LEAD_A $changed(SERIAL_CLOCK_O))
        else $error("phase one first edge misplaced");
    select_release_a: assert property (m_last_cap |-> release_after_tail)
        else $error("select not released one period after last capture");
    gap_pulse_a: assert property ($rose(FRAME_SELECT_N_O) |->
        (FRAME_SELECT_N_O) [*8])
        else $error("select high pulse too short");
    hold_select_a: assert property (m_cont |=> (!FRAME_SELECT_N_O) [*8])
        else $error("select rose between phase one words");
    slave_freeze_a: assert property ((!r.sel_sync[1] && !$past(r.sel_sync[1])) |->
        $stable(r.slv_word))
        else $error("slave word changed while selected");
    clock_frame_a: assert property (($changed(SERIAL_CLOCK_O) &&
        ($past(CLOCK_IDLE_POLARITY) == $past(CLOCK_IDLE_POLARITY, 2))) |-> !FRAME_SELECT_N_O)
        else $error("clock toggled outside a frame");
endmodule : sft_top

/* File: hdl/sft_pkg.sv */
// Constants and types for the SPI frame sequencer
package sft_pkg;
    // Word width and transmit buffer depth
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    // System clock period and serial clock half period
    localparam int CLK_SYS_PERIOD_NS = 25;
    localparam int SCLK_HALF_NS = 250;
    // Half period in system cycles, never below one
    localparam int HALF_CYC = (SCLK_HALF_NS / CLK_SYS_PERIOD_NS < 1) ? 1 :
        SCLK_HALF_NS / CLK_SYS_PERIOD_NS;
    // Half period counter
    localparam int HCNT_W = 8;
    localparam logic [HCNT_W-1:0] HALF_LAST = HCNT_W'(HALF_CYC - 1);
    localparam logic [HCNT_W-1:0] HCNT_RST = 8'h00;
    // Edge counter
    localparam int ECNT_W = 6;
    localparam logic [ECNT_W-1:0] ECNT_RST = 6'h00;
    // Frame length limits, stored as length minus one
    localparam logic [3:0] BITS_M1_MIN = 4'h3;
    localparam logic [3:0] BIT_IDX_RST = 4'h0;
    // Half periods spent in the tail state before release, by phase
    localparam logic [1:0] TAIL_PH0 = 2'h1;
    localparam logic [1:0] TAIL_PH1 = 2'h2;
    // Idle line levels and reset values
    localparam logic SEL_IDLE = 1'b1;
    localparam logic TX_IDLE = 1'b0;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    // Master sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_SHIFT,
        ST_TAIL,
        ST_GAP
    } sft_state_t;
endpackage : sft_pkg

/* File: test/sft_peer.sv */
// Far-side serial model: slave to the master role, master to the slave role
module sft_peer (
    // Lines seen from the block
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic tx_line,
    // Frame setup
    input wire logic pol,
    input wire logic pha,
    input wire logic [4:0] nb,
    // Line into the block, own clock and select
    output logic rx_line,
    output logic s_clk,
    output logic s_sel_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ans[$]; // Words to answer with
    logic [15:0] cur, rcv, got_word; // Word out, shifter, last word in
    int k, c; // Bits launched, bits captured
    realtime tgot; // Time of last capture of a word
    event got; // Word received
    wire cap = sclk ^ pol ^ pha; // Rises on capture edges
    initial begin
        rx_line = 1'b0;
        s_clk = 1'b0;
        s_sel_n = 1'b1;
    end
    // New word at every select fall, its MSB driven at once while phase is zero
    always @(negedge sel_n) begin
        cur = ans.size() ? ans.pop_front() : 16'h0000;
        c = 0;
        k = 0;
        if (!pha) begin
            rx_line = cur[nb-1];
            k = 1;
        end
    end
    // Capture, most significant bit first
    always @(posedge cap) if (sel_n === 1'b0) begin
        rcv = {rcv[14:0], tx_line};
        c++;
        if (c == nb) begin
            got_word = rcv & ~(16'hffff << nb);
            tgot = $realtime;
            c = 0;
            -> got;
        end
    end
    // Launch; phase one reloads after a whole word
    always @(negedge cap) if (sel_n === 1'b0) begin
        if (pha && k == nb) begin
            cur = ans.size() ? ans.pop_front() : 16'h0000;
            k = 0;
        end
        if (k < nb) begin
            rx_line = cur[nb-1-k];
            k++;
        end
    end
    // Released line shows the inverse of its last value
    always @(posedge sel_n) rx_line = ~rx_line;
    // Acting master on its own 32 ns clock, running only inside the frame
    task automatic mxfer();
        logic [15:0] w;
        w = ans.size() ? ans.pop_front() : 16'h0000;
        s_clk = pol;
        #57;
        s_sel_n = 1'b0;
        #200;
        for (int i = nb - 1; i >= 0; i--) begin
            if (pha) s_clk = ~s_clk;
            rx_line = w[i];
            #16;
            // Block's line taken just before the capture edge moves it
            rcv = {rcv[14:0], tx_line};
            s_clk = ~s_clk;
            #16;
            if (!pha) s_clk = ~s_clk;
        end
        got_word = rcv & ~(16'hffff << nb);
        -> got;
        #16;
        rx_line = ~rx_line;
        s_sel_n = 1'b1;
        #300;
    endtask : mxfer
endmodule : sft_peer

/* File: test/tb_spi_frame_timing.sv */
// Self-checking bench for the SPI frame sequencer
module tb_spi_frame_timing import sft_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, en, slv, pol, pha; // Clock, reset, setup
    logic [3:0] bm1; // Frame length minus one
    logic [WORD_W-1:0] txd, rxd; // Stream words
    logic txv, txr, rxv, busy; // Handshakes and status
    logic sco, scoe, sso, ssoe, tdo, tdoe; // Pad outputs
    logic prx, pclk, psel; // Peer lines
    logic [WORD_W-1:0] exp_wire[$], exp_rx[$]; // Expected words
    int error_cnt, comparisons, rises; // Counters
    logic [31:0] rng; // Random state
    sft_top DUT (.CLK_SYS(clk), .SYS_RST(rst), .PORT_ENABLE(en), .SLAVE_MODE(slv),
        .CLOCK_IDLE_POLARITY(pol), .CLOCK_CAPTURE_PHASE(pha), .FRAME_BITS_M1(bm1),
        .TX_DATA(txd), .TX_VALID(txv), .TX_READY(txr), .RX_DATA(rxd), .RX_VALID(rxv),
        .BUSY(busy), .SERIAL_CLOCK_I(pclk), .SERIAL_CLOCK_O(sco), .SERIAL_CLOCK_OE(scoe),
        .FRAME_SELECT_N_I(psel), .FRAME_SELECT_N_O(sso), .FRAME_SELECT_N_OE(ssoe),
        .SERIAL_TX_LINE_O(tdo), .SERIAL_TX_LINE_OE(tdoe), .SERIAL_RX_LINE_I(prx));
    // Peer's slave half sees only what the block drives
    sft_peer peer (.sclk(scoe ? sco : pol), .sel_n(ssoe ? sso : 1'b1),
        .tx_line(tdoe ? tdo : ~tdo), .pol(pol), .pha(pha), .nb({1'b0, bm1} + 5'h01),
        .rx_line(prx), .s_clk(pclk), .s_sel_n(psel));
    // System clock, 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Word compare
    task automatic cmp_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    // Pad level compare
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({15'h0000, got}, {15'h0000, exp});
    endtask : cmp_bit
    // Verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    // Random step
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Offer one word, note what both ends should see
    task automatic push(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] r);
        logic [WORD_W-1:0] m;
        m = ~(16'hffff << (bm1 + 1));
        txd <= w;
        txv <= 1'b1;
        exp_wire.push_back(w & m);
        peer.ans.push_back(r);
        exp_rx.push_back(r & m);
        do @(posedge clk); while (txr !== 1'b1);
    endtask : push
    // Bounded wait for all notes to be met and the port idle
    task automatic settle();
        int n;
        n = 0;
        while ((exp_wire.size() || exp_rx.size() || busy !== 1'b0) && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) begin
            error_cnt++;
            $display("mismatch at %0t: port did not settle", $time);
        end
        @(posedge clk);
    endtask : settle
    // Idle levels of a master
    task automatic idle_chk();
        cmp_bit(sco, pol);
        cmp_bit(sso, SEL_IDLE);
        cmp_bit(tdo, TX_IDLE);
        cmp_bit(scoe, 1'b1);
        cmp_bit(busy, 1'b0);
    endtask : idle_chk
    // Received words against the oldest note
    always @(posedge clk) if (rxv === 1'b1) cmp_word(rxd, exp_rx.size() ? exp_rx.pop_front() : 'x);
    // Words seen on the wire by the peer
    always @(peer.got) cmp_word(peer.got_word, exp_wire.size() ? exp_wire.pop_front() : 'x);
    // Each select release comes one bit period after the last capture
    always @(posedge sso) if (slv === 1'b0 && $time > 300) begin
        rises++;
        cmp_bit((($realtime - peer.tgot) > 475.0) && (($realtime - peer.tgot) < 550.0), 1'b1);
    end
    // Watchdog, far beyond the hundred or so microseconds of the tests
    initial begin
        #1000000;
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        en = 1'b0;
        slv = 1'b0;
        pol = 1'b0;
        pha = 1'b0;
        bm1 = 4'h3;
        txd = 16'h0000;
        txv = 1'b0;
        rng = 32'd32721;
        error_cnt = 0;
        comparisons = 0;
        rises = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Fill while disabled until refused, then drain
        for (int i = 0; i < 8; i++) push(16'h5a00 + 16'(i), 16'h00c3 ^ 16'(i));
        txv <= 1'b0;
        repeat (40) @(posedge clk);
        cmp_bit(txr, 1'b0);
        cmp_word(16'(rises), 16'h0000);
        en <= 1'b1;
        settle();
        cmp_word(16'(rises), 16'h0008);
        $display("test fill and drain done");
        // Every polarity and phase, three words back to back
        for (int m = 0; m < 4; m++) begin
            pol <= m[1];
            pha <= m[0];
            bm1 <= (m == 0) ? 4'h3 : (m == 3) ? 4'hf : 4'(4'h3 + rng % 13);
            repeat (3) @(posedge clk);
            idle_chk();
            rises = 0;
            for (int i = 0; i < 3; i++) begin
                rng = xs(rng);
                push(rng[15:0], rng[31:16]);
            end
            txv <= 1'b0;
            cmp_bit(busy, 1'b1);
            settle();
            cmp_word(16'(rises), pha ? 16'h0001 : 16'h0003);
            $display("test mode %0d done", m);
        end
        // Slave role on the peer's clock
        slv <= 1'b1;
        bm1 <= 4'h7;
        for (int m = 1; m < 3; m++) begin
            pol <= m[1];
            pha <= m[0];
            repeat (3) @(posedge clk);
            cmp_bit(scoe, 1'b0);
            cmp_bit(ssoe, 1'b0);
            cmp_bit(tdo, TX_IDLE);
            // Block sends the buffered word while the peer clocks its own
            rng = xs(rng);
            push(rng[15:0], rng[31:16]);
            txv <= 1'b0;
            peer.mxfer();
            settle();
            $display("test slave mode %0d done", m);
        end
        close_out();
    end
endmodule : tb_spi_frame_timing
